// ---- bench/eeu_pipe_model.sv ----
/*
  Pipeline model: a fetch address that follows every redirect, and a drain
  window that keeps older instructions busy after a slow return request.
  Assumes the bench changes requests just after the rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module eeu_pipe_model (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        redirect,
    input  wire logic [31:0] redirect_addr,
    input  wire logic        rfi_req,
    input  wire logic        slow,
    output logic [31:0]      fetch,
    output logic             busy
);
    logic [1:0] drain;

    // older work drains
    // Busy is up at the request edge itself, so a slow return must wait.
    assign busy = (drain != 2'h0) || (rfi_req && slow);

    // Fetch walks forward one word a cycle and jumps on every redirect.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fetch <= 32'h00010000;
            drain <= 2'h0;
        end else begin
            fetch <= redirect ? redirect_addr : fetch + 32'h4;
            drain <= (rfi_req && slow) ? 2'h2 : ((drain != 2'h0) ? drain - 2'h1 : 2'h0);
        end
    end
endmodule : eeu_pipe_model
`default_nettype wire

// ---- bench/exception_entry_exit_control_tb_top.sv ----
/*
  Self-checking bench of the exception entry and return block.
  Assumes the pipeline model supplies fetch address and drain state.
*/
`timescale 1ns/10ps
`default_nettype none
module exception_entry_exit_control_tb_top;
    import eeu_pkg::*;
    logic        sys_clk;
    logic        nrst;
    logic [11:0] ev;
    logic        pend;
    logic        slow;
    logic [9:0]  info;
    eeu_exc_t    stype;
    logic        spr_wr;
    eeu_spr_t    spr_sel;
    logic [31:0] spr_wdata;
    logic [31:0] spr_rdata, msw, redirect_addr, fetch, a, fa, v;
    logic        redirect, rfi_done, checkstop, busy, dn;
    logic [6:0]  flags;
    eeu_exc_t    ttype;
    int          k;
    int          num_errors = 0;
    int          compares = 0;
    // Event bits: ext smi dec sup fp done branch fpexc rfi sync mchk sreset.
    logic [31:0] t_msw [12] = '{32'h8000, 32'h8000, 32'h8000, 32'h4000, 32'h0, 32'h400,
                               32'h200, 32'h800, 32'h0, 32'h0, 32'h2000, 32'h0};
    logic [11:0] t_ev [12] = '{12'h001, 12'h002, 12'h004, 12'h008, 12'h010, 12'h020,
                              12'h060, 12'h080, 12'h001, 12'h080, 12'h010, 12'h020};
    logic [31:0] t_exp [12] = '{32'h500, 32'h1400, 32'h900, 32'h700, 32'h800, 32'hD00,
                               32'hD00, 32'h700, 32'h0, 32'h0, 32'h0, 32'h0};

    eeu_ctrl #(.MC_N(4)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .sreset_pin(ev[11]), .mchk_pin({3'h0, ev[10]}),
        .ext_int(ev[0]), .smi_int(ev[1]), .dec_int(ev[2]), .older_exc_pending(pend),
        .older_busy(busy), .cur_addr(fetch), .next_addr(fetch + 32'h4), .sync_req(ev[9]),
        .sync_type(stype), .sync_info(info), .instr_done(ev[5]), .instr_is_branch(ev[6]),
        .sup_instr(ev[3]), .fp_instr(ev[4]), .fp_exc_cond(ev[7]), .rfi_req(ev[8]),
        .spr_wr(spr_wr), .spr_sel(spr_sel), .spr_wdata(spr_wdata), .spr_rdata(spr_rdata),
        .msw(msw), .redirect(redirect), .redirect_addr(redirect_addr), .taken_type(ttype),
        .rfi_done(rfi_done), .checkstop(checkstop), .user_mode(flags[6]),
        .fp_dispatch_en(flags[5]), .float_mode(flags[4:3]), .instr_xlate(flags[2]),
        .data_xlate(flags[1]), .little_endian(flags[0]));

    eeu_pipe_model pipe (
        .sys_clk(sys_clk), .nrst(nrst), .redirect(redirect), .redirect_addr(redirect_addr),
        .rfi_req(ev[8]), .slow(slow), .fetch(fetch), .busy(busy));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input eeu_spr_t s, input logic [31:0] d);
        spr_sel = s;
        spr_wdata = d;
        spr_wr = 1'b1;
        @(posedge sys_clk) #1;
        spr_wr = 1'b0;
        @(posedge sys_clk) #1;
    endtask : wr

    task automatic rd(input eeu_spr_t s);
        spr_sel = s;
        @(posedge sys_clk) #1;
        v = spr_rdata;
    endtask : rd

    // One-cycle event, then a bounded look for the redirect and its cycle.
    task automatic fire(input logic [11:0] e);
        fa = fetch;
        a = 32'h0;
        k = 0;
        dn = 1'b0;
        ev = e;
        for (int i = 1; i <= 6; i++) begin
            @(posedge sys_clk) #1;
            if (i == 1) ev = 12'h000;
            if (redirect === 1'b1) begin
                a = redirect_addr;
                k = i;
                dn = rfi_done;
            end
        end
    endtask : fire

    task automatic wrap_up();
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // Free-running 20 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Watchdog at 5000 cycles, well past the fewer than two hundred cycles the tests need.
    initial begin
        #250000;
        num_errors++;
        wrap_up();
    end

    // Main sequence.
    initial begin
        nrst = 1'b0;
        ev = 12'h000;
        pend = 1'b0;
        slow = 1'b0;
        info = 10'h000;
        stype = EEU_X_ITLB;
        spr_wr = 1'b0;
        spr_sel = EEU_SPR_MSW;
        spr_wdata = 32'h0;
        repeat (8) @(posedge sys_clk);
        #1 nrst = 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
        rd(EEU_SPR_MSW);
        chk("msw_reset", 32'h00000040, v);
        wr(EEU_SPR_MSW, 32'hFFFFFFFF);
        chk("msw_mask", 32'h0007FF73, msw);
        chk("flags", 32'h7F, {25'h0, flags});
        fire(12'h001);
        chk("ext_addr", 32'hFFF00500, a);
        chk("ext_type", {28'h0, EEU_X_EXT}, {28'h0, ttype});
        chk("ext_msw", 32'h00011041, msw);
        rd(EEU_SPR_RET);
        chk("ret_addr", fa + 32'h4, v);
        rd(EEU_SPR_SAVED);
        chk("saved_msw", 32'h0000FF73, v);
        // Handler clears the recoverable bit and sets both saves before return.
        wr(EEU_SPR_RET, 32'h00002000);
        wr(EEU_SPR_SAVED, 32'h00028030);
        slow = 1'b1;
        fire(12'h100);
        slow = 1'b0;
        chk("rfi_addr", 32'h00002000, a);
        chk("rfi_wait", 32'h4, k);
        chk("rfi_done", 32'h1, {31'h0, dn});
        chk("rfi_msw", 32'h00008030, msw);
        for (int i = 0; i < 12; i++) begin
            wr(EEU_SPR_MSW, t_msw[i]);
            fire(t_ev[i]);
            chk("vector", t_exp[i], a);
        end
        wr(EEU_SPR_MSW, 32'h0);
        info = 10'h2A5;
        fire(12'h200);
        chk("tlb_addr", 32'h00001000, a);
        chk("tlb_msw", 32'h00020000, msw);
        rd(EEU_SPR_RET);
        chk("tlb_ret_addr", fa, v);
        rd(EEU_SPR_SAVED);
        chk("tlb_saved_msw", 32'h50250000, v);
        pend = 1'b1;
        fire(12'h800);
        chk("sreset", 32'h00000100, a);
        wr(EEU_SPR_MSW, 32'h8000);
        fire(12'h001);
        chk("pending", 32'h0, a);
        pend = 1'b0;
        wr(EEU_SPR_MSW, 32'h1000);
        fire(12'h400);
        chk("mc_off", 32'h0, a);
        wr(EEU_SPR_CFG, 32'h1);
        fire(12'h400);
        chk("mc_on", 32'h00000200, a);
        wr(EEU_SPR_MSW, 32'h0);
        fire(12'h400);
        chk("mc_stop", 32'h1, {31'h0, checkstop});
        wr(EEU_SPR_MSW, 32'h8000);
        rd(EEU_SPR_MSW);
        chk("stop_hold", 32'h0, v);
        wrap_up();
    end
endmodule : exception_entry_exit_control_tb_top
`default_nettype wire

// ---- verilog/eeu_ctrl.sv ----
/*
  Exception entry and return control with the machine state word and the
  two save registers.
  Assumes the pipeline drives its requests on sys_clk; the reset and
  machine check pins are asynchronous and are synchronised here.
*/
// Notes on behaviour
// - User bit set allows only user instructions.
// - Float bit clear blocks all float dispatch.
// - Machine check enable gates machine checks.
// - Disabled machine check enters checkstop.
// - Single step traps after next completion.
// - Branch trace traps after each branch.
// - Two trap bits encode float exception mode.
// - Float traps ignored when both bits zero.
// - Handler address is prefix base plus offset.
// - Two bits enable instruction/data translation.
// - Entry clears both translation bits.
// - Recoverable bit reports interrupted state recoverability.
// - Byte order bit selects big/little endian.
// - Async interrupts need enable; entry clears it.
// - System reset is never masked.
// - Config register enables each machine check source.
// - Take only enabled, after older exceptions.
// - Entry loads return address by type.
// - Entry loads saved state: info plus copies.
// - New state and saves ready at handler fetch.
// - Return waits for older instructions to finish.
// - Return restores state word from saved copy.
// - Entry copies exception endian into byte order.
// - TLB miss sets remap bit; return clears.
`timescale 1ns/10ps
`default_nettype none
`include "eeu_defs.svh"
module eeu_ctrl #(
    parameter int MC_N = 4
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              sreset_pin,
    input  wire logic [MC_N-1:0]   mchk_pin,
    input  wire logic              ext_int,
    input  wire logic              smi_int,
    input  wire logic              dec_int,
    input  wire logic              older_exc_pending,
    input  wire logic              older_busy,
    input  wire logic [31:0]       cur_addr,
    input  wire logic [31:0]       next_addr,
    input  wire logic              sync_req,
    input  wire eeu_pkg::eeu_exc_t sync_type,
    input  wire logic [9:0]        sync_info,
    input  wire logic              instr_done,
    input  wire logic              instr_is_branch,
    input  wire logic              sup_instr,
    input  wire logic              fp_instr,
    input  wire logic              fp_exc_cond,
    input  wire logic              rfi_req,
    input  wire logic              spr_wr,
    input  wire eeu_pkg::eeu_spr_t spr_sel,
    input  wire logic [31:0]       spr_wdata,
    output logic [31:0]            spr_rdata,
    output logic [31:0]            msw,
    output logic                   redirect,
    output logic [31:0]            redirect_addr,
    output eeu_pkg::eeu_exc_t      taken_type,
    output logic                   rfi_done,
    output logic                   checkstop,
    output logic                   user_mode,
    output logic                   fp_dispatch_en,
    output logic [1:0]             float_mode,
    output logic                   instr_xlate,
    output logic                   data_xlate,
    output logic                   little_endian
);
    import eeu_pkg::*;

    logic              rst_q1;
    logic              rst_n;
    logic [MC_N:0]     pin_s1;
    logic [MC_N:0]     pin_s2;
    logic [MC_N:0]     pin_s3;
    logic              sreset_evt;
    logic              mchk_any;
    eeu_state_t        state;
    eeu_state_t        next_state;
    logic [31:0]       ret_addr;
    logic [31:0]       saved_msw;
    logic [31:0]       cfg;
    logic [31:0]       next_msw;
    logic [31:0]       next_ret_addr;
    logic [31:0]       next_saved_msw;
    logic [31:0]       next_cfg;
    logic [31:0]       next_rdata;
    logic              next_redirect;
    logic [31:0]       next_raddr;
    eeu_exc_t          next_type;
    logic              next_rfi_done;
    logic              enter;
    logic              restore;
    logic              mc_stop;
    logic [9:0]        info;

    eeu_sel_if sel ();

    eeu_select u_select (
        .s (sel.arb)
    );

    // Reset release through two flops so every flop leaves reset together.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // Pin synchronisers; the third stage only serves the edge detector.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
        end else begin
            pin_s1 <= {sreset_pin, mchk_pin};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Rising edges only, so a held pin raises one exception, not a stream.
    assign sreset_evt = pin_s2[MC_N] & ~pin_s3[MC_N];
    assign mchk_any = |(pin_s2[MC_N-1:0] & ~pin_s3[MC_N-1:0] & cfg[MC_N-1:0]);

    // Requests to the selector, each already gated by its enable.
    always_comb begin
        sel.sreset    = sreset_evt;
        sel.mchk      = mchk_any & msw[`EEU_MCHK_EN];
        sel.hold      = older_exc_pending;
        sel.sync_req  = sync_req;
        sel.sync_type = sync_type;
        // float traps need a mode bit
        sel.prog      = (sup_instr & msw[`EEU_USER]) |
                        (fp_exc_cond & (msw[`EEU_TRAP_A] | msw[`EEU_TRAP_B]));
        sel.fpu       = fp_instr & ~msw[`EEU_FLOAT_AV];
        sel.trace     = instr_done &
                        (msw[`EEU_STEP] | (msw[`EEU_BR_TRACE] & instr_is_branch));
        sel.smi       = smi_int & msw[`EEU_ASYNC_EN];
        sel.ext       = ext_int & msw[`EEU_ASYNC_EN];
        sel.dec       = dec_int & msw[`EEU_ASYNC_EN];
    end

    // Control state, registers and redirect. Hardware entry and return are
    // applied after software writes, so they win a same-cycle collision.
    always_comb begin
        next_state    = state;
        next_msw      = msw;
        next_ret_addr  = ret_addr;
        next_saved_msw = saved_msw;
        next_cfg       = cfg;
        next_redirect = 1'b0;
        next_raddr    = redirect_addr;
        next_type     = taken_type;
        next_rfi_done = 1'b0;
        enter         = 1'b0;
        restore       = 1'b0;
        mc_stop       = mchk_any & ~msw[`EEU_MCHK_EN] & ~sreset_evt;
        info          = (sync_req & ~sreset_evt & ~sel.mchk) ? sync_info : 10'h000;
        if (spr_wr && state != EEU_STOP) begin
            case (spr_sel)
                EEU_SPR_MSW:  next_msw  = spr_wdata & `EEU_MSW_WMASK;
                EEU_SPR_RET:   next_ret_addr  = spr_wdata;
                EEU_SPR_SAVED: next_saved_msw = spr_wdata;
                default:       next_cfg       = spr_wdata;
            endcase
        end
        case (state)
            EEU_RUN: begin
                if (mc_stop) begin
                    next_state = EEU_STOP;
                end else if (sel.take) begin
                    enter = 1'b1;
                end else if (rfi_req) begin
                    if (older_busy) begin
                        next_state = EEU_RFI_WAIT;
                    end else begin
                        restore = 1'b1;
                    end
                end
            end
            EEU_RFI_WAIT: begin
                if (mc_stop) begin
                    next_state = EEU_STOP;
                end else if (sel.take) begin
                    enter      = 1'b1;
                    next_state = EEU_RUN;
                end else if (!older_busy) begin
                    restore    = 1'b1;
                    next_state = EEU_RUN;
                end
            end
            EEU_STOP: begin
                next_state = EEU_STOP;
            end
            default: next_state = EEU_RUN;
        endcase
        if (enter) begin
            next_ret_addr = sel.use_next ? next_addr : cur_addr;
            next_saved_msw = {1'b0, info[9:6], msw[26:22], info[5:0], msw[15:0]};
            next_msw  = msw & ~`EEU_ENTRY_CLR;
            next_msw[`EEU_BYTE_SWAP] = msw[`EEU_EXC_ENDIAN];
            next_msw[`EEU_REMAP] = (sel.sel_type == EEU_X_ITLB) ||
                                   (sel.sel_type == EEU_X_DTLB_LD) ||
                                   (sel.sel_type == EEU_X_DTLB_ST);
            next_raddr = {msw[`EEU_PREFIX] ? `EEU_BASE_HIGH : `EEU_BASE_LOW, sel.vec};
            next_redirect = 1'b1;
            next_type     = sel.sel_type;
        end
        if (restore) begin
            next_msw = saved_msw & `EEU_MSW_WMASK;
            next_msw[`EEU_REMAP] = 1'b0;
            next_raddr    = ret_addr;
            next_redirect = 1'b1;
            next_rfi_done = 1'b1;
        end
        case (spr_sel)
            EEU_SPR_MSW:  next_rdata = msw;
            EEU_SPR_RET:   next_rdata = ret_addr;
            EEU_SPR_SAVED: next_rdata = saved_msw;
            default:       next_rdata = cfg;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= EEU_RUN;
            msw           <= `EEU_MSW_RESET;
            ret_addr      <= 32'h00000000;
            saved_msw     <= 32'h00000000;
            cfg           <= `EEU_CFG_RESET;
            spr_rdata     <= 32'h00000000;
            redirect      <= 1'b0;
            redirect_addr <= 32'h00000000;
            taken_type    <= EEU_X_SRESET;
            rfi_done      <= 1'b0;
            checkstop     <= 1'b0;
        end else begin
            state         <= next_state;
            msw           <= next_msw;
            ret_addr      <= next_ret_addr;
            saved_msw     <= next_saved_msw;
            cfg           <= next_cfg;
            spr_rdata     <= next_rdata;
            redirect      <= next_redirect;
            redirect_addr <= next_raddr;
            taken_type    <= next_type;
            rfi_done      <= next_rfi_done;
            checkstop     <= (next_state == EEU_STOP);
        end
    end

    // Decoded controls, each one or two bits of the state word flop.
    // user, float, float mode, translation and byte order controls
    assign user_mode      = msw[`EEU_USER];
    assign fp_dispatch_en = msw[`EEU_FLOAT_AV];
    assign float_mode     = {msw[`EEU_TRAP_A], msw[`EEU_TRAP_B]};
    assign instr_xlate    = msw[`EEU_IXLATE];
    assign data_xlate     = msw[`EEU_DXLATE];
    assign little_endian  = msw[`EEU_BYTE_SWAP];

    property p_entry_xlate;
        @(posedge sys_clk) disable iff (!rst_n)
        enter |=> !msw[`EEU_IXLATE] && !msw[`EEU_DXLATE] && redirect;
    endproperty
    a_entry_xlate: assert property (p_entry_xlate)
        else $error("Translation not cleared on entry.");

    property p_entry_ee;
        @(posedge sys_clk) disable iff (!rst_n)
        enter |=> !msw[`EEU_ASYNC_EN];
    endproperty
    a_entry_ee: assert property (p_entry_ee)
        else $error("Async enable not cleared on entry.");

    property p_entry_le;
        @(posedge sys_clk) disable iff (!rst_n)
        enter |=> msw[`EEU_BYTE_SWAP] == $past(msw[`EEU_EXC_ENDIAN]);
    endproperty
    a_entry_le: assert property (p_entry_le)
        else $error("Byte order not taken from exception endian bit.");

    property p_saved_machine_state_copy;
        @(posedge sys_clk) disable iff (!rst_n)
        enter |=> saved_msw[15:0] == $past(msw[15:0]) &&
                  saved_msw[26:22] == $past(msw[26:22]);
    endproperty
    a_saved_machine_state_copy: assert property (p_saved_machine_state_copy)
        else $error("Saved state copy wrong.");

    property p_base;
        @(posedge sys_clk) disable iff (!rst_n)
        enter |=> redirect_addr[31:20] ==
                  ($past(msw[`EEU_PREFIX]) ? `EEU_BASE_HIGH : `EEU_BASE_LOW);
    endproperty
    a_base: assert property (p_base)
        else $error("Handler base wrong.");

    property p_stop_holds;
        @(posedge sys_clk) disable iff (!rst_n)
        checkstop |=> checkstop && !redirect;
    endproperty
    a_stop_holds: assert property (p_stop_holds)
        else $error("Checkstop left without reset.");

    property p_mc_stop;
        @(posedge sys_clk) disable iff (!rst_n)
        (mc_stop && state != EEU_STOP) |=> checkstop && !redirect;
    endproperty
    a_mc_stop: assert property (p_mc_stop)
        else $error("Disabled machine check did not checkstop.");

    property p_sreset;
        @(posedge sys_clk) disable iff (!rst_n)
        (sreset_evt && state != EEU_STOP) |=> redirect && taken_type == EEU_X_SRESET;
    endproperty
    a_sreset: assert property (p_sreset)
        else $error("System reset was masked.");

    property p_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (older_exc_pending && !sreset_evt) |=> !redirect || rfi_done;
    endproperty
    a_hold: assert property (p_hold)
        else $error("Exception taken past an older one.");

    property p_rfi;
        @(posedge sys_clk) disable iff (!rst_n)
        rfi_done |-> !$past(older_busy) && redirect_addr == $past(ret_addr) &&
                     msw == ($past(saved_msw) & `EEU_MSW_WMASK & ~(32'h1 << `EEU_REMAP));
    endproperty
    a_rfi: assert property (p_rfi)
        else $error("Return did not restore state.");
endmodule : eeu_ctrl
`default_nettype wire

// ---- verilog/eeu_defs.svh ----
/*
  Bit positions, masks, reset values and vector offsets of the exception
  entry and return control block.
  Assumes index 0 is the least significant bit of the 32-bit state word.
*/
`ifndef EEU_DEFS_SVH
`define EEU_DEFS_SVH

// State word field positions.
`define EEU_POW   18
`define EEU_REMAP      17
`define EEU_EXC_ENDIAN 16
`define EEU_ASYNC_EN   15
`define EEU_USER       14
`define EEU_FLOAT_AV   13
`define EEU_MCHK_EN    12
`define EEU_TRAP_A     11
`define EEU_STEP       10
`define EEU_BR_TRACE   9
`define EEU_TRAP_B     8
`define EEU_PREFIX     6
`define EEU_IXLATE     5
`define EEU_DXLATE     4
`define EEU_RECOV      1
`define EEU_BYTE_SWAP  0

// Implemented bits, bits cleared on entry, and reset values.
`define EEU_MSW_WMASK   32'h0007FF73
`define EEU_ENTRY_CLR   32'h0006EF33
`define EEU_MSW_RESET   32'h00000040
`define EEU_CFG_RESET   32'h00000000

// Upper twelve address bits of the handler base.
`define EEU_BASE_LOW    12'h000
`define EEU_BASE_HIGH   12'hFFF

// Vector offsets.
`define EEU_VEC_SRESET  20'h00100
`define EEU_VEC_MCHK    20'h00200
`define EEU_VEC_DSI     20'h00300
`define EEU_VEC_ISI     20'h00400
`define EEU_VEC_EXT     20'h00500
`define EEU_VEC_ALIGN   20'h00600
`define EEU_VEC_PROG    20'h00700
`define EEU_VEC_FPU     20'h00800
`define EEU_VEC_DEC     20'h00900
`define EEU_VEC_SC      20'h00C00
`define EEU_VEC_TRACE   20'h00D00
`define EEU_VEC_ITLB    20'h01000
`define EEU_VEC_DTLB_LD 20'h01100
`define EEU_VEC_DTLB_ST 20'h01200
`define EEU_VEC_IABR    20'h01300
`define EEU_VEC_SMI     20'h01400

`endif

// ---- verilog/eeu_pkg.sv ----
/*
  Types of the exception entry and return control block.
  Assumes nothing of its surroundings.
*/
package eeu_pkg;
    typedef enum logic [2:0] {
        EEU_RUN      = 3'h1,
        EEU_RFI_WAIT = 3'h2,
        EEU_STOP     = 3'h4
    } eeu_state_t;

    typedef enum logic [3:0] {
        EEU_X_SRESET = 4'h0, EEU_X_MCHK    = 4'h1, EEU_X_DSI     = 4'h2,
        EEU_X_ISI    = 4'h3, EEU_X_EXT     = 4'h4, EEU_X_ALIGN   = 4'h5,
        EEU_X_PROG   = 4'h6, EEU_X_FPU     = 4'h7, EEU_X_DEC     = 4'h8,
        EEU_X_SC     = 4'h9, EEU_X_TRACE   = 4'hA, EEU_X_ITLB    = 4'hB,
        EEU_X_DTLB_LD = 4'hC, EEU_X_DTLB_ST = 4'hD, EEU_X_IABR   = 4'hE,
        EEU_X_SMI    = 4'hF
    } eeu_exc_t;

    typedef enum logic [1:0] {
        EEU_SPR_MSW  = 2'h0,
        EEU_SPR_RET   = 2'h1,
        EEU_SPR_SAVED = 2'h2,
        EEU_SPR_CFG   = 2'h3
    } eeu_spr_t;
endpackage : eeu_pkg

// ---- verilog/eeu_sel_if.sv ----
/*
  Carrier between the control core and the exception selector.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface eeu_sel_if;
    logic              sreset;
    logic              mchk;
    logic              hold;
    logic              sync_req;
    eeu_pkg::eeu_exc_t sync_type;
    logic              prog;
    logic              fpu;
    logic              trace;
    logic              smi;
    logic              ext;
    logic              dec;
    logic              take;
    logic              use_next;
    eeu_pkg::eeu_exc_t sel_type;
    logic [19:0]       vec;

    modport arb (input sreset, mchk, hold, sync_req, sync_type, prog, fpu,
                 trace, smi, ext, dec,
                 output take, use_next, sel_type, vec);
    modport core (output sreset, mchk, hold, sync_req, sync_type, prog, fpu,
                  trace, smi, ext, dec,
                  input take, use_next, sel_type, vec);
endinterface : eeu_sel_if
`default_nettype wire

// ---- verilog/eeu_select.sv ----
/*
  Exception selector: picks the highest priority enabled request and its
  vector offset. Purely combinational.
  Assumes the core has already applied every enable to the requests.
*/
`timescale 1ns/10ps
`default_nettype none
`include "eeu_defs.svh"
module eeu_select (
    eeu_sel_if.arb s
);
    import eeu_pkg::*;

    // Fixed priority; only system reset passes an older pending exception.
    always_comb begin
        s.take     = 1'b0;
        s.use_next = 1'b0;
        s.sel_type = EEU_X_SRESET;
        if (s.sreset) begin
            s.take = 1'b1;
        end
        else if (!s.hold) begin
            s.take = s.mchk | s.sync_req | s.prog | s.fpu | s.trace |
                     s.smi | s.ext | s.dec;
            if (s.mchk) begin
                s.sel_type = EEU_X_MCHK;
                s.use_next = 1'b1;
            end else if (s.sync_req) begin
                s.sel_type = s.sync_type;
            end else if (s.prog) begin
                s.sel_type = EEU_X_PROG;
            end else if (s.fpu) begin
                s.sel_type = EEU_X_FPU;
            end else if (s.trace) begin
                s.sel_type = EEU_X_TRACE;
                s.use_next = 1'b1;
            end else if (s.smi) begin
                s.sel_type = EEU_X_SMI;
                s.use_next = 1'b1;
            end else if (s.ext) begin
                s.sel_type = EEU_X_EXT;
                s.use_next = 1'b1;
            end else begin
                s.sel_type = EEU_X_DEC;
                s.use_next = 1'b1;
            end
        end
    end

    // Vector offset of the selected exception.
    always_comb begin
        case (s.sel_type)
            EEU_X_SRESET:  s.vec = `EEU_VEC_SRESET;
            EEU_X_MCHK:    s.vec = `EEU_VEC_MCHK;
            EEU_X_DSI:     s.vec = `EEU_VEC_DSI;
            EEU_X_ISI:     s.vec = `EEU_VEC_ISI;
            EEU_X_EXT:     s.vec = `EEU_VEC_EXT;
            EEU_X_ALIGN:   s.vec = `EEU_VEC_ALIGN;
            EEU_X_PROG:    s.vec = `EEU_VEC_PROG;
            EEU_X_FPU:     s.vec = `EEU_VEC_FPU;
            EEU_X_DEC:     s.vec = `EEU_VEC_DEC;
            EEU_X_SC:      s.vec = `EEU_VEC_SC;
            EEU_X_TRACE:   s.vec = `EEU_VEC_TRACE;
            EEU_X_ITLB:    s.vec = `EEU_VEC_ITLB;
            EEU_X_DTLB_LD: s.vec = `EEU_VEC_DTLB_LD;
            EEU_X_DTLB_ST: s.vec = `EEU_VEC_DTLB_ST;
            EEU_X_IABR:    s.vec = `EEU_VEC_IABR;
            default:       s.vec = `EEU_VEC_SMI;
        endcase
    end
endmodule : eeu_select
`default_nettype wire
